// [shared/lhsp_pkg.sv]
// Constants for the serial host port of the line interface unit.
// Assumes a host master that drives chip select, shift clock and data.
package lhsp_pkg;
    // =========================================================
    // Frame layout
    localparam int unsigned LHSP_ADDR_W  = 5;
    localparam int unsigned LHSP_DATA_W  = 8;
    localparam int unsigned LHSP_NREG    = 32;
    localparam int unsigned LHSP_NCHAN   = 4;
    localparam int unsigned LHSP_CNT_W   = 5;
    localparam logic        LHSP_RD_FLAG = 1'b1;
    // Bit in each command register: single rail enable per channel.
    localparam int unsigned LHSP_SR_BIT  = 0;
    // Bit in each command register: receiver power down.
    localparam int unsigned LHSP_OFF_BIT = 1;
    // Bit in each command register: recovered clock invert.
    localparam int unsigned LHSP_INV_BIT = 2;
    localparam logic [7:0]  LHSP_REG_RST = 8'h00;
    // =========================================================
    // Frame states
    typedef enum logic [1:0] {
        LHSP_ST_CMD,
        LHSP_ST_ADDR,
        LHSP_ST_DATA,
        LHSP_ST_DONE
    } lhsp_state_t;
endpackage : lhsp_pkg

// [verilog/lhsp_sync.sv]
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module lhsp_sync
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Level
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;
    logic q_r;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end
        else
        begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule : lhsp_sync

// [verilog/lhsp_host_port.sv]
// Serial host port with command registers and hardware mode pin decode.
// Assumes shift clock runs only within chip-select frames in host mode.
`timescale 1ns/1ps
// Overview of operation
// - Chip select and register reset read high when left undriven.
// - Serial input bits are taken on the rising shift clock edge.
// - Read data changes on the falling shift clock edge.
// - A read shifts the addressed register out on the serial output.
// - The serial output floats after the data transfer ends.
// - A low register reset in host mode restores all register defaults.
// - In hardware mode shift clock high powers down all receivers.
// - In hardware mode register reset selects recovered clock inversion.
// - In hardware mode chip select high selects single rail operation.
module lhsp_host_port
    import lhsp_pkg::*;
#(
    parameter int unsigned ADDR_W = LHSP_ADDR_W,
    parameter int unsigned DATA_W = LHSP_DATA_W,
    parameter int unsigned NREG   = LHSP_NREG
)
(
    // Core clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    // Mode: high selects host mode
    input  wire logic                  host_mode_i,
    // Serial pins; undriven state given as pull-up flags
    input  wire logic                  chip_sel_n_i,
    input  wire logic                  chip_sel_float_i,
    input  wire logic                  shift_clk_i,
    input  wire logic                  serial_in_pin_i,
    output logic                       serial_out_pin_o,
    output logic                       serial_out_oe_o,
    input  wire logic                  register_reset_n_i,
    input  wire logic                  register_reset_float_i,
    // Configuration to the channels, core clock domain
    output logic [LHSP_NCHAN-1:0]      single_rail_select_o,
    output logic [LHSP_NCHAN-1:0]      receiver_shutoff_o,
    output logic [LHSP_NCHAN-1:0]      recovered_clock_invert_o,
    output logic [LHSP_NCHAN-1:0]      code_violation_en_o
);
    if (ADDR_W < 2 || DATA_W < 3 || NREG > (1 << ADDR_W) ||
        NREG < LHSP_NCHAN || ADDR_W + DATA_W >= (1 << LHSP_CNT_W))
    begin : g_bad_param
        $error("lhsp_host_port: unsupported parameters");
    end
    // =========================================================
    // Pad level with pull-ups
    logic cs_n;
    logic register_reset_n_n;
    assign cs_n   = chip_sel_float_i ? 1'b1 : chip_sel_n_i;
    assign register_reset_n_n = register_reset_float_i ? 1'b1 : register_reset_n_i;

    // Link reset: chip select high or hardware mode clears the frame.
    logic link_rst_n;
    assign link_rst_n = rst_n_i & ~cs_n & host_mode_i;

    // =========================================================
    // Register file, written in core domain
    logic [DATA_W-1:0] regs_r [NREG];
    logic [DATA_W-1:0] regs_nxt [NREG];

    // =========================================================
    // Link-side frame receiver on the shift clock
    lhsp_state_t       st_r, st_nxt;
    logic [LHSP_CNT_W-1:0] cnt_r, cnt_nxt;
    logic              rd_r, rd_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdat_r, wdat_nxt;
    logic              wtog_r, wtog_nxt;

    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        rd_nxt   = rd_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        wtog_nxt = wtog_r;
        case (st_r)
            LHSP_ST_CMD:
            begin
                rd_nxt  = (serial_in_pin_i == LHSP_RD_FLAG);
                cnt_nxt = '0;
                st_nxt  = LHSP_ST_ADDR;
            end
            LHSP_ST_ADDR:
            begin
                addr_nxt = {addr_r[ADDR_W-2:0], serial_in_pin_i};
                cnt_nxt  = cnt_r + 1'b1;
                if (cnt_r == LHSP_CNT_W'(ADDR_W - 1))
                begin
                    cnt_nxt = '0;
                    st_nxt  = LHSP_ST_DATA;
                end
            end
            LHSP_ST_DATA:
            begin
                wdat_nxt = {wdat_r[DATA_W-2:0], serial_in_pin_i};
                cnt_nxt  = cnt_r + 1'b1;
                if (cnt_r == LHSP_CNT_W'(DATA_W - 1))
                begin
                    st_nxt = LHSP_ST_DONE;
                    if (!rd_r)
                        wtog_nxt = ~wtog_r;
                end
            end
            default:
                st_nxt = LHSP_ST_DONE;
        endcase
    end
    always_ff @(posedge shift_clk_i or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            st_r   <= LHSP_ST_CMD;
            cnt_r  <= '0;
            rd_r   <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            rd_r   <= rd_nxt;
        end
    end
    // Write toggle, address and data outlive chip select so that the
    // core still finds them stable when it takes the write.
    always_ff @(posedge shift_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wtog_r <= 1'b0;
            addr_r <= '0;
            wdat_r <= '0;
        end
        else
        begin
            wtog_r <= wtog_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
        end
    end
    // =========================================================
    // Read shifter on the falling shift clock
    logic [DATA_W-1:0] sh_r, sh_nxt;
    logic              oe_r, oe_nxt;
    logic [DATA_W-1:0] rd_word;
    assign rd_word = (int'(addr_r) < NREG) ? regs_r[addr_r] : '0;

    always_comb
    begin
        sh_nxt = sh_r;
        oe_nxt = 1'b0;
        if (st_r == LHSP_ST_DATA && rd_r)
        begin
            oe_nxt = 1'b1;
            if (cnt_r == '0)
                sh_nxt = rd_word;
            else
                sh_nxt = {sh_r[DATA_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge shift_clk_i or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            sh_r <= '0;
            oe_r <= 1'b0;
        end
        else
        begin
            sh_r <= sh_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign serial_out_pin_o = sh_r[DATA_W-1];
    assign serial_out_oe_o  = oe_r;

    // =========================================================
    // Crossings into the core domain
    logic wtog_s, register_reset_n_s, receiver_shutoff_s, cs_s, host_s;
    logic wtog_seen_r, wtog_seen_nxt;
    lhsp_sync u_wtog (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
                      .d_i(wtog_r), .q_o(wtog_s));
    lhsp_sync u_register_reset_n (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
                      .d_i(register_reset_n_n), .q_o(register_reset_n_s));
    lhsp_sync u_rxof (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
                      .d_i(shift_clk_i), .q_o(receiver_shutoff_s));
    lhsp_sync u_cs   (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
                      .d_i(cs_n), .q_o(cs_s));
    lhsp_sync u_host (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
                      .d_i(host_mode_i), .q_o(host_s));

    always_comb
    begin
        wtog_seen_nxt = wtog_s;
        for (int i = 0; i < NREG; i++)
        begin
            regs_nxt[i] = regs_r[i];
            if (host_s && !register_reset_n_s)
                regs_nxt[i] = DATA_W'(LHSP_REG_RST);
            else if (wtog_s != wtog_seen_r && int'(addr_r) == i)
                regs_nxt[i] = wdat_r;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wtog_seen_r <= 1'b0;
            for (int i = 0; i < NREG; i++)
                regs_r[i] <= DATA_W'(LHSP_REG_RST);
        end
        else
        begin
            wtog_seen_r <= wtog_seen_nxt;
            for (int i = 0; i < NREG; i++)
                regs_r[i] <= regs_nxt[i];
        end
    end

    // =========================================================
    // Per-channel configuration outputs
    logic [LHSP_NCHAN-1:0] sr_r, off_r, inv_r;
    logic [LHSP_NCHAN-1:0] sr_nxt, off_nxt, inv_nxt;
    genvar g;
    generate
        for (g = 0; g < LHSP_NCHAN; g++)
        begin : g_chan
            always_comb
            begin
                sr_nxt[g]  = host_s ? regs_r[g][LHSP_SR_BIT] : cs_s;
                off_nxt[g] = host_s ? regs_r[g][LHSP_OFF_BIT] : receiver_shutoff_s;
                inv_nxt[g] = host_s ? regs_r[g][LHSP_INV_BIT]
                                    : ~register_reset_n_s;
            end
        end
    endgenerate
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sr_r  <= '0;
            off_r <= '0;
            inv_r <= '0;
        end
        else
        begin
            sr_r  <= sr_nxt;
            off_r <= off_nxt;
            inv_r <= inv_nxt;
        end
    end

    assign single_rail_select_o     = sr_r;
    assign receiver_shutoff_o       = off_r;
    assign recovered_clock_invert_o = inv_r;
    assign code_violation_en_o      = sr_r;
    // =========================================================
    // Checks
    sequence s_hw_off;
        !host_s && receiver_shutoff_s;
    endsequence
    chk_hw_shutoff: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_hw_off |=> (&receiver_shutoff_o))
        else $error("shutoff not applied");
    chk_hw_single: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (!host_s && cs_s) |=>
        (&single_rail_select_o) && (&code_violation_en_o))
        else $error("single rail not applied");
    chk_hw_invert: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (!host_s && !register_reset_n_s) |=>
        (&recovered_clock_invert_o))
        else $error("clock invert not applied");
    chk_reg_reset: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (host_s && !register_reset_n_s) |=>
        regs_r[0] == DATA_W'(LHSP_REG_RST))
        else $error("register reset missed");
    chk_oe_idle: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) cs_n |-> !serial_out_oe_o)
        else $error("output driven while deselected");
    chk_oe_write: assert property (@(negedge shift_clk_i)
        disable iff (!link_rst_n) (!rd_r) |=> !serial_out_oe_o)
        else $error("output driven on write");
    chk_cnt_range: assert property (@(posedge shift_clk_i)
        disable iff (!link_rst_n) st_r == LHSP_ST_ADDR |->
        cnt_r < LHSP_CNT_W'(ADDR_W))
        else $error("address count out of range");
    chk_no_abort_wr: assert property (@(posedge shift_clk_i)
        disable iff (!rst_n_i) (st_r != LHSP_ST_DATA) |=>
        $stable(wtog_r))
        else $error("write outside data phase");
endmodule : lhsp_host_port

// [sim/lhsp_host_model.sv]
// Host master model for the serial host port.
// Assumes the bench calls xfer and set_pins; shift clock idles low.
`timescale 1ns/1ps
module lhsp_host_model
(
    // Serial pins toward the port
    output logic      chip_sel_n_o,
    output logic      shift_clk_o,
    output logic      serial_in_o,
    input  wire logic serial_out_i,
    input  wire logic serial_out_oe_i
);
    localparam time HALF = 24ns;
    // =========================================================
    // Idle levels
    initial
    begin
        chip_sel_n_o = 1'b1;
        shift_clk_o  = 1'b0;
        serial_in_o  = 1'b0;
    end
    // Drives pin levels directly for hardware mode.
    task automatic set_pins(input logic cs_n, input logic sck);
        chip_sel_n_o = cs_n;
        shift_clk_o  = sck;
    endtask : set_pins
    // =========================================================
    // One frame of nbits bits; reads sample just before the rising edge.
    task automatic xfer(input logic rd, input logic [4:0] adr,
                        input logic [7:0] dat, input int nbits,
                        output logic [7:0] q, output logic oe_mid,
                        output logic oe_end);
        logic [13:0] frame;
        frame  = {rd, adr, dat};
        q      = 8'h00;
        oe_mid = 1'b0;
        chip_sel_n_o = 1'b0;
        #HALF;
        for (int i = 0; i < nbits; i++)
        begin
            shift_clk_o = 1'b0;
            serial_in_o = frame[13-i];
            #HALF;
            // A released output reads inverted, so a late drive shows up.
            if (i >= 6)
                q = {q[6:0], serial_out_oe_i ? serial_out_i : ~serial_out_i};
            if (i == 6)
                oe_mid = serial_out_oe_i;
            shift_clk_o = 1'b1;
            #HALF;
        end
        shift_clk_o = 1'b0;
        #HALF;
        oe_end       = serial_out_oe_i;
        chip_sel_n_o = 1'b1;
        serial_in_o  = ~serial_in_o;
        #100ns;
    endtask : xfer
endmodule : lhsp_host_model

// [sim/lhsp_host_port_bench.sv]
// Self-checking bench for the serial host port.
// Assumes lhsp_host_model drives the serial pins; also needs lhsp_pkg, lhsp_host_port and lhsp_sync.
`timescale 1ns/1ps
module lhsp_host_port_bench;
    import lhsp_pkg::*;
    logic       core_clk_i, rst_n_i, host_mode_i, chip_sel_float_i;
    logic       register_reset_n_i, register_reset_float_i;
    logic       cs_n, sck, serial_in_pin, serial_out_pin, oe, om, oz;
    logic [3:0] sr, off, inv, cv;
    logic [7:0] q;
    int         errors, n_checks;
    // =========================================================
    // Design and host
    lhsp_host_port dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .host_mode_i(host_mode_i), .chip_sel_n_i(cs_n),
        .chip_sel_float_i(chip_sel_float_i), .shift_clk_i(sck),
        .serial_in_pin_i(serial_in_pin), .serial_out_pin_o(serial_out_pin),
        .serial_out_oe_o(oe), .register_reset_n_i(register_reset_n_i),
        .register_reset_float_i(register_reset_float_i),
        .single_rail_select_o(sr), .receiver_shutoff_o(off),
        .recovered_clock_invert_o(inv), .code_violation_en_o(cv));
    lhsp_host_model host (.chip_sel_n_o(cs_n), .shift_clk_o(sck),
        .serial_in_o(serial_in_pin), .serial_out_i(serial_out_pin), .serial_out_oe_i(oe));
    always #5 core_clk_i = ~core_clk_i;
    // =========================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic outs(input logic [3:0] s, input logic [3:0] o,
                        input logic [3:0] v);
        chk(sr, s, "single rail");
        chk(off, o, "shutoff");
        chk(inv, v, "invert");
        chk(cv, s, "violation en");
    endtask : outs
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, 14, q, om, oz);
        tick(10);
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        host.xfer(LHSP_RD_FLAG, a, 8'h00, 14, q, om, oz);
        chk(q, exp, "read data");
        chk(om, 1'b1, "oe in data");
        chk(oz, 1'b0, "oe after");
        tick(10);
    endtask : rd_chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // =========================================================
    // Scenarios
    task automatic t_reset;
        outs(4'h0, 4'h0, 4'h0);
        chk(oe, 1'b0, "oe idle");
        $display("test reset done");
    endtask : t_reset
    task automatic t_write_read;
        wr(5'h01, 8'h05);
        wr(5'h03, 8'h02);
        outs(4'h2, 4'h8, 4'h2);
        rd_chk(5'h01, 8'h05);
        wr(5'h11, 8'ha5);
        rd_chk(5'h11, 8'ha5);
        $display("test write read done");
    endtask : t_write_read
    task automatic t_abort;
        host.xfer(1'b0, 5'h02, 8'h07, 10, q, om, oz);
        rd_chk(5'h02, 8'h00);
        chip_sel_float_i = 1'b1;
        wr(5'h02, 8'h07);
        chip_sel_float_i = 1'b0;
        rd_chk(5'h02, 8'h00);
        outs(4'h2, 4'h8, 4'h2);
        $display("test abort done");
    endtask : t_abort
    task automatic t_register_reset_n;
        register_reset_float_i = 1'b1;
        register_reset_n_i     = 1'b0;
        tick(10);
        outs(4'h2, 4'h8, 4'h2);
        register_reset_float_i = 1'b0;
        tick(10);
        outs(4'h0, 4'h0, 4'h0);
        register_reset_n_i = 1'b1;
        tick(5);
        rd_chk(5'h11, 8'h00);
        $display("test register reset done");
    endtask : t_register_reset_n
    task automatic t_hw;
        host_mode_i = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            host.set_pins(~i[0], i[1]);
            register_reset_n_i = ~(i[0] ^ i[1]);
            tick(10);
            outs({4{~i[0]}}, {4{i[1]}}, {4{i[0] ^ i[1]}});
        end
        host.set_pins(1'b1, 1'b0);
        register_reset_n_i = 1'b1;
        host_mode_i = 1'b1;
        tick(10);
        $display("test hardware mode done");
    endtask : t_hw
    // =========================================================
    // Main sequence and watchdog
    initial
    begin
        core_clk_i = 1'b0;
        rst_n_i = 1'b0;
        host_mode_i = 1'b1;
        chip_sel_float_i = 1'b0;
        register_reset_n_i = 1'b1;
        register_reset_float_i = 1'b0;
        errors = 0;
        n_checks = 0;
        tick(16);
        rst_n_i = 1'b1;
        tick(4);
        t_reset();
        t_write_read();
        t_abort();
        t_register_reset_n();
        t_hw();
        tally_and_finish();
    end
    initial
    begin
        #200us;
        errors++;
        tally_and_finish();
    end
endmodule : lhsp_host_port_bench
